// ===== common/cpa_pkg.sv
package cpa_pkg;
   localparam int unsigned DIV_W = 32;
   localparam int unsigned ADJ_W = 34;
   localparam logic [DIV_W-1:0] MIN_PART = 32'h0000_0002;
   localparam logic [DIV_W-1:0] ONE = 32'h0000_0001;
   localparam logic [DIV_W-1:0] RST_DIV = 32'h0000_0008;
   localparam logic [1:0] RST_SWING = 2'h0;
   localparam logic [2:0] RST_CMODE = 3'h0;
   localparam logic [1:0] RST_IMP = 2'h0;
   localparam logic [2:0] RST_SUPPLY = 3'h0;
   localparam int unsigned CFG_W = 12;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HIGH = 2'b01,
      ST_LOW = 2'b10
   } phase_t;
endpackage

// ===== rtl/cfg_shadow.sv
`timescale 1ns/1ps
// Holds buffer settings; loads only when told the output is at a safe point
module cfg_shadow (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [cpa_pkg::CFG_W-1:0] cfg_i,
   output logic [cpa_pkg::CFG_W-1:0] cfg_o
);
   logic [cpa_pkg::CFG_W-1:0] cfg_d;
   logic [cpa_pkg::CFG_W-1:0] cfg_q;
   localparam logic [cpa_pkg::CFG_W-1:0] CFG_RST = {1'b0, 1'b1, cpa_pkg::RST_SWING,
      cpa_pkg::RST_CMODE, cpa_pkg::RST_IMP, cpa_pkg::RST_SUPPLY};

   always_comb begin
      cfg_d = cfg_q;
      if (load_i) begin
         cfg_d = cfg_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= CFG_RST;
      end else if (ce_i) begin
         cfg_q <= cfg_d;
      end
   end

   assign cfg_o = cfg_q;
endmodule

// ===== rtl/output_coarse_phase_adjust.sv
`timescale 1ns/1ps
// How it works
// [R1] Each output has its own coarse adjuster, moving edges by whole divider-clock periods.
// [R2] Adjustment stretches or shrinks the high part, low part, or both.
// [R3] Shortened parts never drop below two periods high and two low; excess clipped.
// [R4] Software must not coarse-adjust outputs with divide ratio one to four.
// [R5] One adjustment spans up to 2^32 periods high plus 2^32 low.
// [R6] Positive lengthens, negative shortens; whole adjustment lands in one output period.
// [R7] At 50% duty the adjustment is split about equally between high and low.
// [R8] With programmed pulse width the whole adjustment goes to the low part.
// [R9] Any number of successive adjustments is accepted; large shifts best split up.
// [R10] Buffer runs as one differential or two single-ended outputs.
// [R11] Two-bit swing code picks 410, 600, 750 or 900 mV.
// [R12] Three-bit common-mode code picks 0.9 V to 2.3 V in 0.2 V steps.
// [R13] Single-ended drives two copies; complement copy may be inverted.
// [R14] Single-ended offers four impedance settings per supply level.
// [R15] Integer divider divides the divider clock by a 32-bit ratio.
// [R16] Default 50% duty; optional 32-bit high width below the ratio.
// [R17] Pulses are high-going; complement pin with inversion gives low-going.
// [R18] Written adjustment latched, applied at next period; new writes wait until consumed.
// [R19] Buffer settings change only at period start, avoiding runt pulses.
module output_coarse_phase_adjust (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [cpa_pkg::DIV_W-1:0] divide_ratio_i,
   input wire logic pulse_mode_i,
   input wire logic [cpa_pkg::DIV_W-1:0] pulse_width_i,
   input wire logic [cpa_pkg::ADJ_W-1:0] coarse_phase_offset_i,
   input wire logic offset_write_i,
   output logic offset_ready_o,
   input wire logic diff_mode_i,
   input wire logic complement_invert_i,
   input wire logic [1:0] swing_select_i,
   input wire logic [2:0] common_mode_select_i,
   input wire logic [1:0] impedance_select_i,
   input wire logic [2:0] supply_level_select_i,
   output logic true_output_o,
   output logic complement_output_o,
   output logic diff_mode_o,
   output logic [1:0] swing_select_o,
   output logic [2:0] common_mode_select_o,
   output logic [1:0] impedance_select_o,
   output logic [2:0] supply_level_select_o,
   output logic adjust_applied_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Adjustment holding register
   logic pend_d, pend_q;
   logic signed [cpa_pkg::ADJ_W-1:0] adj_d, adj_q;
   logic take_adj;

   assign offset_ready_o = !pend_q; // [R18]

   always_comb begin
      pend_d = pend_q;
      adj_d = adj_q;
      if (take_adj) begin
         pend_d = 1'b0;
      end
      if (offset_write_i && !pend_q) begin // [R18] [R9]
         pend_d = 1'b1;
         adj_d = coarse_phase_offset_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         adj_q <= '0;
      end else if (ce_i) begin
         pend_q <= pend_d;
         adj_q <= adj_d;
      end
   end

   // A taken write must block the next one until its period start
   sequence s_write_taken;
      ce_i && offset_write_i && offset_ready_o;
   endsequence
   sequence s_write_held;
      !offset_ready_o;
   endsequence
   property p_ready;
      @(posedge clk_i) disable iff (rst_i) s_write_taken |=> s_write_held;
   endproperty
   a_ready: assert property (p_ready) else $error("write not latched"); // [R18]

   ////////////////////////////////////////////////////////////////////////////////
   // Part lengths for the coming period
   // Signed 35-bit math keeps 2^32 stretch plus base in range without wrap
   logic signed [cpa_pkg::ADJ_W:0] base_hi, base_lo, add_hi, add_lo, sum_hi, sum_lo;
   logic [cpa_pkg::ADJ_W-1:0] len_hi, len_lo;
   logic [cpa_pkg::DIV_W-1:0] hi_nom;

   always_comb begin
      if (pulse_mode_i) begin
         hi_nom = pulse_width_i; // [R16] [R17]
      end else begin
         hi_nom = divide_ratio_i >> 1; // [R15] [R16]
      end
      base_hi = $signed({3'b000, hi_nom});
      base_lo = $signed({3'b000, divide_ratio_i - hi_nom});
      add_hi = '0;
      add_lo = '0;
      if (pend_q) begin
         if (pulse_mode_i) begin
            add_lo = {adj_q[cpa_pkg::ADJ_W-1], adj_q}; // [R8]
         end else begin
            add_hi = {{2{adj_q[cpa_pkg::ADJ_W-1]}}, adj_q[cpa_pkg::ADJ_W-1:1]}; // [R7] [R2]
            add_lo = {adj_q[cpa_pkg::ADJ_W-1], adj_q} - add_hi; // [R7]
         end
      end
      sum_hi = base_hi + add_hi; // [R6] [R5]
      sum_lo = base_lo + add_lo;
      if (sum_hi < $signed({3'b000, cpa_pkg::MIN_PART})) begin // [R3]
         len_hi = {2'b00, cpa_pkg::MIN_PART};
      end else begin
         len_hi = sum_hi[cpa_pkg::ADJ_W-1:0];
      end
      if (sum_lo < $signed({3'b000, cpa_pkg::MIN_PART})) begin // [R3]
         len_lo = {2'b00, cpa_pkg::MIN_PART};
      end else begin
         len_lo = sum_lo[cpa_pkg::ADJ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output divider state machine, one state per clock part
   cpa_pkg::phase_t st_d, st_q;
   logic [cpa_pkg::ADJ_W-1:0] cnt_d, cnt_q, lo_d, lo_q;
   logic out_d, out_q, applied_d, applied_q, period_start;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      lo_d = lo_q;
      out_d = out_q;
      applied_d = 1'b0;
      take_adj = 1'b0;
      period_start = 1'b0;
      case (st_q)
         cpa_pkg::ST_IDLE: begin
            period_start = 1'b1;
         end
         cpa_pkg::ST_HIGH: begin
            cnt_d = cnt_q - {2'b00, cpa_pkg::ONE};
            if (cnt_q == {2'b00, cpa_pkg::ONE}) begin
               st_d = cpa_pkg::ST_LOW;
               cnt_d = lo_q;
               out_d = 1'b0;
            end
         end
         cpa_pkg::ST_LOW: begin
            cnt_d = cnt_q - {2'b00, cpa_pkg::ONE};
            if (cnt_q == {2'b00, cpa_pkg::ONE}) begin
               period_start = 1'b1;
            end
         end
         default: begin
            st_d = cpa_pkg::ST_IDLE;
         end
      endcase
      if (period_start) begin // [R1] [R6]
         st_d = cpa_pkg::ST_HIGH;
         cnt_d = len_hi;
         lo_d = len_lo;
         out_d = 1'b1;
         take_adj = pend_q; // [R18]
         applied_d = pend_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= cpa_pkg::ST_IDLE;
         cnt_q <= '0;
         lo_q <= '0;
         out_q <= 1'b0;
         applied_q <= 1'b0;
      end else if (ce_i) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         lo_q <= lo_d;
         out_q <= out_d;
         applied_q <= applied_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer configuration, swapped only at period start
   logic [cpa_pkg::CFG_W-1:0] cfg_cur;

   cfg_shadow u_cfg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .load_i(period_start), // [R19]
      .cfg_i({diff_mode_i, complement_invert_i, swing_select_i, common_mode_select_i,
         impedance_select_i, supply_level_select_i}), // [R10] [R11] [R12] [R14]
      .cfg_o(cfg_cur)
   );

   assign diff_mode_o = cfg_cur[11]; // [R10]
   assign swing_select_o = cfg_cur[9:8]; // [R11]
   assign common_mode_select_o = cfg_cur[7:5]; // [R12]
   assign impedance_select_o = cfg_cur[4:3]; // [R14]
   assign supply_level_select_o = cfg_cur[2:0]; // [R14]
   assign true_output_o = out_q;
   // Differential always complements; inverting single-ended is the quieter setting
   assign complement_output_o = (cfg_cur[11] | cfg_cur[10]) ? !out_q : out_q; // [R13] [R17]
   assign adjust_applied_o = applied_q;


   ////////////////////////////////////////////////////////////////////////////////
   // Period shape and settings checks
   sequence s_period_start;
      ce_i && period_start;
   endsequence

   property p_clip_hi;
      @(posedge clk_i) disable iff (rst_i)
         s_period_start |-> len_hi >= {2'b00, cpa_pkg::MIN_PART};
   endproperty
   a_clip_hi: assert property (p_clip_hi) else $error("high part below minimum"); // [R3]

   property p_clip_lo;
      @(posedge clk_i) disable iff (rst_i)
         s_period_start |-> len_lo >= {2'b00, cpa_pkg::MIN_PART};
   endproperty
   a_clip_lo: assert property (p_clip_lo) else $error("low part below minimum"); // [R3]

   // Consumed adjustment shows one pulse and frees the holding register
   property p_apply;
      @(posedge clk_i) disable iff (rst_i)
         (s_period_start ##0 pend_q) |=> (adjust_applied_o && offset_ready_o);
   endproperty
   a_apply: assert property (p_apply) else $error("adjustment not consumed"); // [R18]

   // Settings may only move at a period start
   property p_cfg_hold;
      @(posedge clk_i) disable iff (rst_i) !(ce_i && period_start) |=> $stable(cfg_cur);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved mid period"); // [R19]

   // Catches a clipped part that still came out one cycle long
   property p_min_high;
      @(posedge clk_i) disable iff (rst_i) $rose(true_output_o) |=> true_output_o;
   endproperty
   a_min_high: assert property (p_min_high) else $error("high part too short"); // [R3]

   property p_min_low;
      @(posedge clk_i) disable iff (rst_i) $fell(true_output_o) |=> !true_output_o;
   endproperty
   a_min_low: assert property (p_min_low) else $error("low part too short"); // [R3]
endmodule

// ===== verif/clock_receiver.sv
`timescale 1ns/1ps
// Downstream receiver: measures high and low lengths of each output period
module clock_receiver (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clk_in_i,
   output logic [31:0] high_len_o,
   output logic [31:0] low_len_o,
   output logic period_o
);
   ////////////////////////////////////////////////////////////////////////
   logic last_q;
   logic [31:0] cnt_q;
   // Counts in divider-clock samples, so lengths are whole periods
   always_ff @(posedge clk_i) begin
      period_o <= 1'b0;
      if (rst_i) begin
         last_q <= 1'b0;
         cnt_q <= 32'h0000_0000;
      end else if (clk_in_i !== last_q) begin
         last_q <= clk_in_i;
         cnt_q <= 32'h0000_0001;
         if (last_q) begin
            high_len_o <= cnt_q;
         end else begin
            low_len_o <= cnt_q;
            period_o <= 1'b1;
         end
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
      end
   end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_i = 0, rst_i = 1, wr = 0, pm = 0, dm = 1, inv = 0, ce = 1;
   logic [31:0] ratio = 32'h0000_0008; // Above four: coarse adjust allowed
   logic [33:0] adj = '0;
   logic [1:0] sw = 2'h0;
   logic [2:0] cm = 3'h0;
   logic tq, cq, dmo, rdy, app, per_o;
   logic [1:0] swo, imo;
   logic [2:0] cmo, suo;
   logic [31:0] hi, lo;
   int fail_count = 0, checks = 0;
   always #25 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////
   output_coarse_phase_adjust uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .divide_ratio_i(ratio), .pulse_mode_i(pm), .pulse_width_i(32'h0000_0003),
      .coarse_phase_offset_i(adj), .offset_write_i(wr), .offset_ready_o(rdy),
      .diff_mode_i(dm), .complement_invert_i(inv), .swing_select_i(sw),
      .common_mode_select_i(cm), .impedance_select_i(sw), .supply_level_select_i(cm),
      .true_output_o(tq), .complement_output_o(cq), .diff_mode_o(dmo),
      .swing_select_o(swo), .common_mode_select_o(cmo), .impedance_select_o(imo),
      .supply_level_select_o(suo), .adjust_applied_o(app));
   clock_receiver rx (.clk_i(clk_i), .rst_i(rst_i), .clk_in_i(tq),
      .high_len_o(hi), .low_len_o(lo), .period_o(per_o));
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] s, input int e);
      checks++;
      if (s !== 32'(e)) begin
         fail_count++;
         $display("FAIL %0t got %0h expected %0h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bounded wait for one completed output period
   task per;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (per_o !== 1'b1 && n < 300);
      chk(per_o, 1);
      @(negedge clk_i);
   endtask
   // Write just after a period start, so the second write hits a pending one
   task adj_t(input int a, input int eh, input int el);
      int n;
      per;
      adj = 34'(a);
      wr = 1;
      @(negedge clk_i);
      // Strobe stays up, so the second value meets a pending one
      chk(rdy, 0);
      adj = 34'(7);
      wr = 1;
      @(negedge clk_i);
      wr = 0;
      n = 0;
      while (app !== 1'b1 && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk(app, 1);
      per;
      chk(app, 0);
      chk(rdy, 1);
      per;
      chk(hi, eh);
      chk(lo, el);
      $display("adjust test done");
   endtask
   // Settings change mid-period, must wait for the period start
   task cfg_t;
      per;
      dm = 0;
      inv = 1;
      sw = 2'h3;
      cm = 3'h5;
      @(negedge clk_i);
      chk(swo, 0);
      per;
      per;
      chk(swo, 3);
      chk(cmo, 5);
      chk(imo, 3);
      chk(suo, 5);
      chk(dmo, 0);
      chk(cq ^ tq, 1);
      inv = 0;
      per;
      per;
      chk(cq ^ tq, 0);
      $display("config test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset state, then the plain 50% period
   task reset_t;
      repeat (2) @(negedge clk_i);
      rst_i = 0;
      chk(rdy, 1);
      chk(dmo, 0);
      chk(cq ^ tq, 1);
      per;
      per;
      chk(hi, 4);
      chk(lo, 4);
      $display("reset test done");
   endtask
   // Enable low for three edges in the high part stretches it by three
   task ce_t;
      per;
      ce = 0;
      repeat (3) @(negedge clk_i);
      chk(tq, 1);
      ce = 1;
      per;
      chk(hi, 7);
      chk(lo, 4);
      $display("clock enable test done");
   endtask
   // Programmed high width, changed mid period
   task pulse_t;
      pm = 1;
      ratio = 32'h0000_000A;
      per;
      per;
      chk(hi, 3);
      chk(lo, 7);
      $display("pulse test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_t;
      adj_t(6, 7, 7);
      adj_t(-10, 2, 2);
      adj_t(1, 4, 5);
      adj_t(-3, 2, 3);
      ce_t;
      cfg_t;
      pulse_t;
      adj_t(5, 3, 12);
      adj_t(-20, 3, 2);
      conclude;
   end
   initial begin
      #200000;
      fail_count++;
      conclude;
   end
endmodule
